// File: hdl/spfc_map.vh
`ifndef SPFC_MAP_VH
`define SPFC_MAP_VH
// Register byte addresses (AXI4-Lite, one word each)
`define SPFC_REG_CSR 8'h37
`define SPFC_REG_INDEX_CSR 8'h37
`define SPFC_ADDR_CSR 8'hdc
`define SPFC_ADDR_STAT 8'he0
// Control/status field positions
`define SPFC_B_EN 0
`define SPFC_B_ERASE 1
`define SPFC_B_WRITE 2
`define SPFC_B_FUSE 3
`define SPFC_B_RWRE 4
`define SPFC_B_SIG 5
`define SPFC_B_BUSY 6
`define SPFC_B_IE 7
`define SPFC_CSR_RESET 8'h00
// Timing: four-cycle window, three-cycle load window
`define SPFC_WINDOW 3'h4
`define SPFC_LOAD_WINDOW 3'h3
// Flash operation time in microseconds, min and max
`define SPFC_OP_MIN_US 3700
`define SPFC_OP_MAX_US 4500
`define SPFC_CLK_MHZ 200
`define SPFC_OSC_MHZ 8
`define SPFC_OSC_DIV 5'h19
// Responses
`define SPFC_RESP_OKAY 2'h0
`define SPFC_RESP_SLVERR 2'h2
`endif

// File: hdl/spfc_top.v
// Functional notes
// - Erase, page write and lock write last 3.7 to 4.5 ms, 8MHz timed.
// - System reset does not abort a running Flash write.
// - Ready interrupt requested while enable and global flag set, store_enable zero.
// - Busy flag sets on erase or write start; section then inaccessible.
// - Busy clears by read-enable after programming, or on page-buffer load.
// - Load within three cycles of signature+enable returns signature entry.
// - No re-enable while busy; read-enable during buffer load discards data.
// - Load within three cycles of fuse+enable returns lock or fuse by Z0.
// - Fuse access with enable: next store writes lock bits from R0.
// - Fuse access bit clears after lock write or four idle cycles.
// - Page write with enable: next store writes buffer to Z page.
// - Page write bit clears on completion or four idle cycles.
// - Page erase with enable: next store erases the Z page.
// - Page erase bit clears on completion or timeout; core halted meanwhile.
// - Store enable arms the store instruction for four cycles only.
// - Enable alone: store puts R1:R0 into buffer word at Z.
// - Enable clears after store or four cycles; held during erase/write.
// - All bits reset zero; busy flag read-only, others read-write.
// - EEPROM write in progress blocks programming and fuse/lock reads.
`include "spfc_map.vh"
`default_nettype none
module spfc_top #(
  parameter OP_CYCLES = 800000
) (
  input wire mclk,
  input wire reset,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core side
  input wire store_to_program_instr,
  input wire load_from_program_instr,
  input wire global_irq_enable,
  input wire [15:0] z_pointer,
  input wire [15:0] r1_r0,
  input wire eeprom_write_busy,
  input wire [7:0] fuse_bits,
  input wire [7:0] lock_bits,
  input wire [7:0] signature_data,
  input wire sys_reset,
  output reg [7:0] load_data,
  output reg load_valid,
  output reg [15:0] buffer_word,
  output reg [15:0] buffer_addr,
  output reg buffer_we,
  output reg buffer_clear,
  output reg [15:0] page_addr,
  output reg [7:0] lock_wdata,
  output reg [2:0] op_kind,
  output wire cpu_halt,
  output wire rw_section_blocked,
  output wire store_ready_irq
);
  // Block overview
  // The core arms a command by writing the control byte over the bus,
  // then issues a store or load on its own strobe inside a short window.
  // Bit 0 is the arm bit; bits 1 to 5 pick what the armed store or load
  // does; bit 6 reports the busy section; bit 7 gates the ready request.

  // Command decode, in priority order:
  //   erase, page write and lock write start a timed operation
  //   section read enable clears the busy flag, emptying the buffer only if the flag was set
  //   signature select only changes what a load returns
  //   arm bit alone fills one buffer word from the core's operands

  // Window handling
  // The store window opens on the edge after the control write and
  // stays open for four edges; the load window for three. When the
  // store window runs out unused, every armed bit drops at once, so a
  // stale command can never be picked up by a later store.
  // A new control write with the arm bit set restarts both windows from the top; one with bit 0 clear closes them.
  // Control writes are refused while an operation runs; the arm bit
  // stays set for the whole operation, so software polls bit 0.

  // Timed operations
  // The length is counted in ticks of the 8MHz time base, made here by
  // dividing the system clock; the divider only runs while an
  // operation is in flight. The core is halted for the whole span,
  // which is simpler than tracking which section the page lies in.
  // Limitation: OP_CYCLES must be a multiple of the divide ratio, or
  // the span is cut short by the remainder.

  // Reset
  // Bus reset and the synchronised system reset act alike on the
  // sequencer. Neither stops an operation in flight: the sequencer, the
  // control byte and the busy flag keep going; bus reset alone also resets the bus side.

  // Page buffer
  // The buffer itself sits outside; this block only hands it words,
  // addresses and a clear strobe. A control write that sets the read
  // enable while words are loaded throws the buffer away.

  // Status word
  // A second bus word shows the loading flag, the synchronised
  // EEPROM busy level and the store window count, for software that
  // wants to see why a store was not taken.

  // Hazards
  // The EEPROM busy level and the global interrupt flag come from
  // other logic on unknown timing, so they pass two flops first; a
  // store that lands during that delay may still be taken.
  // A control write without the lowest byte lane enabled is ignored.

  // One-hot sequencer states
  localparam ST_IDLE = 2'b01;
  localparam ST_OP = 2'b10;

  // Operation length bounds in cycles
  localparam MIN_CYC = `SPFC_OP_MIN_US * `SPFC_CLK_MHZ;
  localparam MAX_CYC = `SPFC_OP_MAX_US * `SPFC_CLK_MHZ;

  reg [7:0] csr_q;
  reg [2:0] win_q;
  reg [2:0] ldwin_q;
  reg [1:0] state_q;
  reg [19:0] tick_q;
  reg [4:0] osc_q;
  reg loading_q;
  // Synchroniser flops for the levels from other logic
  reg eep_s1_q;
  reg eep_s2_q;
  reg gie_s1_q;
  reg gie_s2_q;
  reg srst_s1_q;
  reg srst_s2_q;

  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;

  // Shared check: a command byte means "armed with enable"
  function armed;
    input [7:0] c;
    input integer b;
    begin
      armed = c[`SPFC_B_EN] & c[b];
    end
  endfunction

  // Register decode, shared by the write and read paths
  function is_reg;
    input [7:0] a;
    input [7:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // Asynchronous status inputs pass two flops before use
  always @(posedge mclk) begin
    eep_s1_q <= eeprom_write_busy;
    eep_s2_q <= eep_s1_q;
    gie_s1_q <= global_irq_enable;
    gie_s2_q <= gie_s1_q;
    srst_s1_q <= sys_reset;
    srst_s2_q <= srst_s1_q;
  end

  // AXI write capture: address and data accepted in either order
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire csr_wr = wr_go & is_reg(aw_q, `SPFC_ADDR_CSR) & ws_q[0] &
                ~eep_s2_q;

  always @(posedge mclk) begin
    if (reset) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      // Answer once both halves are held; only the control byte is mapped
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_reg(aw_q, `SPFC_ADDR_CSR) ? `SPFC_RESP_OKAY :
                       `SPFC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read: one-cycle answer; status word shows loading flag, EEPROM busy and window count
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SPFC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SPFC_RESP_OKAY;
      if (is_reg(s_axi_araddr, `SPFC_ADDR_CSR)) begin
        s_axi_rdata <= {24'h0, csr_q};
      end else if (is_reg(s_axi_araddr, `SPFC_ADDR_STAT)) begin
        s_axi_rdata <= {27'h0, loading_q, eep_s2_q, win_q};
      end else begin
        // Unmapped addresses answer with an error and zero data
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `SPFC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Store taken only while the window is open and no operation runs
  wire win_open = (win_q != 3'h0) & (state_q == ST_IDLE);
  wire spm_go = store_to_program_instr & win_open & ~eep_s2_q;
  wire is_erase = armed(csr_q, `SPFC_B_ERASE);
  wire is_write = armed(csr_q, `SPFC_B_WRITE);
  wire is_fuse = armed(csr_q, `SPFC_B_FUSE);
  wire is_rwre = armed(csr_q, `SPFC_B_RWRE);
  wire is_sig = armed(csr_q, `SPFC_B_SIG);
  wire is_load = ~is_erase & ~is_write & ~is_fuse & ~is_rwre & ~is_sig;
  wire long_op = spm_go & (is_erase | is_write | is_fuse);
  wire op_done = (state_q == ST_OP) & (tick_q == 20'h0) &
                 (osc_q == 5'h0);
  // Operation length in 8MHz ticks; only the low bits are needed
  wire [31:0] op_ticks = OP_CYCLES / `SPFC_OSC_DIV;
  // Core-side system reset joins the bus reset, after its synchroniser
  wire rst_any = reset | srst_s2_q;

  // Control register, window counter and the operation sequencer.
  // The sequencer ignores both resets while an operation runs, so a write always finishes.
  always @(posedge mclk) begin
    // A running operation ignores reset so the write always completes;
    // an unknown state at power-up falls through to the reset arm
    if (~rst_any | (state_q == ST_OP)) begin
      buffer_we <= 1'b0;
      buffer_clear <= 1'b0;
      // Control write: arm the windows and keep the busy flag
      if (csr_wr & (state_q == ST_IDLE)) begin
        // Busy flag is read-only; window restarts next cycle
        csr_q <= {w_q[7], csr_q[6], w_q[5:0]};
        win_q <= w_q[0] ? `SPFC_WINDOW : 3'h0;
        ldwin_q <= w_q[0] ? `SPFC_LOAD_WINDOW : 3'h0;
        if (w_q[`SPFC_B_RWRE] & w_q[0] & loading_q) begin
          loading_q <= 1'b0;
          buffer_clear <= 1'b1;
        end
      end else if (spm_go) begin
        // Latch the page address now; the core may reuse Z at once
        win_q <= 3'h0;
        ldwin_q <= 3'h0;
        page_addr <= {z_pointer[15:1], 1'b0};
        if (long_op) begin
          // Long command: halt the core and start the time base
          state_q <= ST_OP;
          tick_q <= op_ticks[19:0] - 20'h1;
          osc_q <= `SPFC_OSC_DIV - 5'h1;
          op_kind <= {is_fuse, is_write, is_erase};
          lock_wdata <= r1_r0[7:0];
          if (is_erase | is_write) begin
            csr_q[`SPFC_B_BUSY] <= 1'b1;
          end
          if (is_write) begin
            loading_q <= 1'b0;
          end
        end else begin
          // Short command: done in this cycle, so all command bits drop
          csr_q[5:0] <= 6'h0;
          if (is_load) begin
            buffer_we <= 1'b1;
            buffer_word <= r1_r0;
            buffer_addr <= {z_pointer[15:1], 1'b0};
            loading_q <= 1'b1;
            csr_q[`SPFC_B_BUSY] <= 1'b0;
          end else if (is_rwre & ~csr_q[`SPFC_B_BUSY]) begin
            csr_q[`SPFC_B_BUSY] <= 1'b0;
          end else if (is_rwre) begin
            csr_q[`SPFC_B_BUSY] <= 1'b0;
            buffer_clear <= 1'b1;
          end
        end
      end else if (state_q == ST_OP) begin
        // Operation timed by divided 8MHz tick
        osc_q <= (osc_q == 5'h0) ? `SPFC_OSC_DIV - 5'h1 : osc_q - 5'h1;
        if (osc_q == 5'h0 && tick_q != 20'h0) begin
          tick_q <= tick_q - 20'h1;
        end
        if (op_done) begin
          state_q <= ST_IDLE;
          csr_q[5:0] <= 6'h0;
          op_kind <= 3'h0;
          if (op_kind[1]) begin
            buffer_clear <= 1'b1;
          end
        end
      end else if (win_q != 3'h0) begin
        // Idle window: count down, drop the command when it runs out
        win_q <= win_q - 3'h1;
        if (ldwin_q != 3'h0) begin
          ldwin_q <= ldwin_q - 3'h1;
        end
        if (win_q == 3'h1) begin
          csr_q[5:0] <= 6'h0;
        end
      end
    end else begin
      csr_q <= `SPFC_CSR_RESET;
      win_q <= 3'h0;
      ldwin_q <= 3'h0;
      state_q <= ST_IDLE;
      tick_q <= 20'h0;
      osc_q <= 5'h0;
      loading_q <= 1'b0;
      page_addr <= 16'h0;
      lock_wdata <= 8'h0;
      op_kind <= 3'h0;
      buffer_we <= 1'b0;
      buffer_clear <= 1'b0;
      buffer_word <= 16'h0;
      buffer_addr <= 16'h0;
    end
  end

  // Load answers: signature or fuse/lock within the three-cycle window
  always @(posedge mclk) begin
    if (reset) begin
      load_data <= 8'h0;
      load_valid <= 1'b0;
    end else begin
      load_valid <= 1'b0;
      // One cycle of data; the core captures it on the next edge
      if (load_from_program_instr & (ldwin_q != 3'h0) & ~eep_s2_q) begin
        if (is_sig) begin
          load_data <= signature_data;
          load_valid <= 1'b1;
        end else if (is_fuse) begin
          load_data <= z_pointer[0] ? fuse_bits : lock_bits;
          load_valid <= 1'b1;
        end
      end
    end
  end

  // Core halts for the whole timed operation
  assign cpu_halt = (state_q == ST_OP);
  // Busy flag drives the section block directly
  assign rw_section_blocked = csr_q[`SPFC_B_BUSY];
  // Level request, repeats as long as enable bit is clear
  assign store_ready_irq = csr_q[`SPFC_B_IE] & gie_s2_q &
                           ~csr_q[`SPFC_B_EN];
endmodule
`default_nettype wire

// File: sim/spfc_checker.sv
`default_nettype none
module spfc_checker #(
  parameter OP_CYCLES = 800000
) (
  input wire mclk,
  input wire reset,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire store_to_program_instr,
  input wire load_from_program_instr,
  input wire global_irq_enable,
  input wire eeprom_write_busy,
  input wire load_valid,
  input wire buffer_we,
  input wire [2:0] op_kind,
  input wire cpu_halt,
  input wire rw_section_blocked,
  input wire store_ready_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  int hc_q = 0;
  // Halt length counter; not reset, since a reset cannot stop an operation
  always @(posedge mclk) begin
    hc_q <= cpu_halt ? hc_q + 1 : 0;
  end
  // Interrupt enable held low long enough to pass the synchroniser
  sequence gie_low;
    !global_irq_enable [*4];
  endsequence
  sequence eep_on;
    eeprom_write_busy [*4];
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  a_load_cause: assert property (load_valid |->
    $past(load_from_program_instr)) else $error("load data without load");
  a_op_time: assert property ($fell(cpu_halt) |->
    hc_q >= OP_CYCLES - 25 && hc_q <= OP_CYCLES + 25)
    else $error("operation time off");
  a_halt_cause: assert property ($rose(cpu_halt) |->
    $past(store_to_program_instr) || $past(store_to_program_instr, 2) ||
    $past(store_to_program_instr, 3)) else $error("halt without store");
  a_busy_on_op: assert property ($rose(cpu_halt) && !op_kind[2] |->
    ##[0:2] rw_section_blocked) else $error("busy flag not set");
  a_irq_halt_off: assert property (cpu_halt |-> !store_ready_irq)
    else $error("ready interrupt during operation");
  a_irq_gie_off: assert property (gie_low |-> !store_ready_irq)
    else $error("ready interrupt without global enable");
  a_eep_block: assert property (eep_on |->
    !buffer_we && !$rose(cpu_halt)) else $error("program during eeprom write");
endmodule
bind spfc_top spfc_checker #(.OP_CYCLES(OP_CYCLES)) u_spfc_checker (.*);
`default_nettype wire

// File: sim/spfc_core_model.sv
`default_nettype none
module spfc_core_model #(
  parameter [7:0] FUSE = 8'h5a,
  parameter [7:0] LOCK = 8'hc3,
  parameter [7:0] SIG = 8'h1e // Arbitrary value
) (
  input wire logic mclk,
  output logic store_to_program_instr,
  output logic load_from_program_instr,
  output logic [15:0] z_pointer,
  output logic [15:0] r1_r0,
  output logic [7:0] fuse_bits,
  output logic [7:0] lock_bits,
  output logic [7:0] signature_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed sources for the fuse, lock and signature loads
  assign fuse_bits = FUSE;
  assign lock_bits = LOCK;
  assign signature_data = SIG;
  initial begin
    store_to_program_instr = 1'h0;
    load_from_program_instr = 1'h0;
    z_pointer = 16'h0000;
    r1_r0 = 16'h0000;
  end
  // One-cycle instruction; operands scrambled after, so stale values show
  task store(input logic [15:0] z, input logic [15:0] r);
    z_pointer <= z;
    r1_r0 <= r;
    store_to_program_instr <= 1'h1;
    @(posedge mclk);
    store_to_program_instr <= 1'h0;
    z_pointer <= ~z;
    r1_r0 <= ~r;
  endtask
  task load(input logic [15:0] z);
    z_pointer <= z;
    load_from_program_instr <= 1'h1;
    @(posedge mclk);
    load_from_program_instr <= 1'h0;
    z_pointer <= ~z;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_spfc_top.sv
`default_nettype none
module tb_spfc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, global_irq_enable = 0, eeprom_write_busy = 0;
  logic sys_reset = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ld_q;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] bw_q;
  logic bc_q = 0;
  logic [1:0] rs;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, store_to_program_instr, load_from_program_instr;
  wire logic load_valid, buffer_we, buffer_clear, cpu_halt;
  wire logic rw_section_blocked, store_ready_irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [2:0] op_kind;
  wire logic [7:0] load_data, lock_wdata, fuse_bits, lock_bits, signature_data;
  wire logic [15:0] z_pointer, r1_r0, buffer_word, buffer_addr, page_addr;
  wire logic [31:0] s_axi_rdata;
  int mismatches = 0, n_tests = 0;
  logic [7:0] cmd [3] = '{8'h03, 8'h05, 8'h09};
  logic [7:0] mid [3] = '{8'h42, 8'h44, 8'h40};
  logic [2:0] kind [3] = '{3'h1, 3'h2, 3'h4};
  logic [7:0] lcmd [3] = '{8'h21, 8'h09, 8'h09};
  // Short op time keeps the run brief
  spfc_top #(.OP_CYCLES(100)) u_spfc_top (.*);
  spfc_core_model u_spfc_core_model (.*);
  always #2.5 mclk = ~mclk;
  // Catch one-cycle result pulses so tasks need not hit the exact edge
  always @(posedge mclk) begin
    if (load_valid) ld_q <= load_data;
    if (buffer_we) bw_q <= buffer_word;
    if (buffer_clear) bc_q <= 1'h1;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task results;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Start a cycle late so a previous release is never overwritten
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task waith(input logic v);
    int n;
    n = 0;
    while (cpu_halt !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk(cpu_halt, v);
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #20us;
    mismatches++;
    results;
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    rd(8'hdc);
    chk(d, 32'h0);
    rd(8'h10);
    chk(rs, 2'h2);
    wr(8'hdc, 32'h40);
    rd(8'hdc);
    chk(d, 32'h0);
    $display("Register access test done");
    for (int i = 0; i < 3; i++) begin
      wr(8'hdc, cmd[i]);
      u_spfc_core_model.store(16'h0040, 16'h12a5);
      waith(1'h1);
      chk(op_kind, kind[i]);
      chk(page_addr, 16'h0040);
      chk(rw_section_blocked, 1'h1);
      if (i == 0) begin
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        chk(cpu_halt, 1'h1);
      end
      rd(8'hdc);
      chk(d & 32'h46, mid[i]);
      if (i == 2) chk(lock_wdata, 8'ha5);
      waith(1'h0);
      rd(8'hdc);
      chk(d & 32'h0f, 32'h0);
      if (i == 0) begin
        bc_q = 1'h0;
        wr(8'hdc, 32'h11);
        u_spfc_core_model.store(16'h0000, 16'h0000);
        rd(8'hdc);
        chk(d, 32'h0);
        chk(bc_q, 1'h1);
      end
    end
    $display("Timed operation test done");
    wr(8'hdc, 32'h01);
    u_spfc_core_model.store(16'h0047, 16'hbeef);
    repeat (3) @(posedge mclk);
    chk(bw_q, 16'hbeef);
    chk(buffer_addr, 16'h0046);
    rd(8'hdc);
    chk(d, 32'h0);
    rd(8'he0);
    chk(d & 32'h10, 32'h10);
    bc_q = 1'h0;
    wr(8'hdc, 32'h11);
    rd(8'he0);
    chk(d & 32'h10, 32'h0);
    chk(bc_q, 1'h1);
    wr(8'hdc, 32'h05);
    repeat (6) @(posedge mclk);
    rd(8'hdc);
    chk(d, 32'h0);
    u_spfc_core_model.store(16'h0040, 16'h0000);
    repeat (3) @(posedge mclk);
    chk(cpu_halt, 1'h0);
    $display("Buffer and window test done");
    for (int i = 0; i < 3; i++) begin
      ld_q = 8'h00;
      wr(8'hdc, lcmd[i]);
      u_spfc_core_model.load({15'h0, i == 2});
      repeat (3) @(posedge mclk);
      chk(ld_q, i == 0 ? signature_data : i == 1 ? lock_bits : fuse_bits);
    end
    $display("Load test done");
    global_irq_enable <= 1'h1;
    wr(8'hdc, 32'h80);
    repeat (4) @(posedge mclk);
    chk(store_ready_irq, 1'h1);
    wr(8'hdc, 32'h81);
    chk(store_ready_irq, 1'h0);
    repeat (8) @(posedge mclk);
    chk(store_ready_irq, 1'h1);
    eeprom_write_busy <= 1'h1;
    wr(8'hdc, 32'h01);
    rd(8'hdc);
    chk(d, 32'h80);
    eeprom_write_busy <= 1'h0;
    $display("Interrupt and eeprom test done");
    results;
  end
endmodule
`default_nettype wire
